// ---- shared/sar_pkg.sv ----
// Constants, register map and types shared by the converter controller.
// Assumes a 50 MHz pclk and an APB master with 32-bit data.
package sar_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int DATA_W = 12;
  localparam int NCH = 9; // Eight pin channels plus the temperature sensor
  localparam int CH_W = 4;
  localparam logic [CH_W-1:0] TEMP_CH = 4'h8;
  localparam real PCLK_MHZ = 50.0;
  localparam real CONV_MAX_MHZ = 18.0;
  // Smallest divide that keeps the conversion clock at or below its limit
  localparam int DIV_MIN = $rtoi($ceil(PCLK_MHZ / CONV_MAX_MHZ));
  localparam int CONV_MIN_CLK = 18;
  localparam int SAMPLE_MIN = 4;
  localparam int SETTLE_CLK = CONV_MIN_CLK - DATA_W - SAMPLE_MIN;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_DIV = 8'h0c;
  localparam logic [7:0] OFF_SSEL = 8'h10;
  localparam logic [7:0] OFF_STIME = 8'h14;
  localparam logic [7:0] OFF_LIMIT = 8'h18;
  localparam logic [7:0] OFF_FWCH = 8'h1c;
  localparam logic [7:0] OFF_STAT = 8'h20;
  localparam logic [7:0] OFF_INTR = 8'h24;
  localparam logic [7:0] OFF_ICLR = 8'h28;
  localparam logic [7:0] OFF_IEN = 8'h2c;
  localparam logic [7:0] OFF_RES = 8'h40;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int LIM_HI_LSB = 16;
  localparam int RES_VALID = 31;
  localparam int INT_EOC = 0;
  localparam int INT_EOS = 1;
  localparam int INT_RANGE = 2;
  localparam int INT_W = 3;
  localparam logic [7:0] DIV_RST = 8'h03;
  localparam logic [31:0] STIME_RST = 32'h40201004;
  localparam logic [DATA_W-1:0] LIM_LO_RST = 12'h000;
  localparam logic [DATA_W-1:0] LIM_HI_RST = 12'hfff;

  // Control register, bit 0 upward: enable, cont, fw_mode, ref_sel[1:0]
  typedef struct packed {
    logic [1:0] ref_sel; // 0 supply, 1 half supply, 2 bandgap, 3 external pin
    logic fw_mode;
    logic cont;
    logic enable;
  } ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SCAN = 3'b010,
    ST_FW = 3'b100
  } seq_st_t;

  typedef enum logic [3:0] {
    CV_IDLE = 4'b0001,
    CV_SAMP = 4'b0010,
    CV_BITS = 4'b0100,
    CV_SETTLE = 4'b1000
  } conv_st_t;

endpackage

// ---- core/sar_conv.sv ----
// Successive-approximation engine: sample window, twelve bit trials, settle.
// Assumes tick pulses at least three pclk apart and a synchronised comparator.
`timescale 1ns/1ps
`default_nettype none
module sar_conv
  import sar_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic start,
  input wire logic abort,
  input wire logic [7:0] samp,
  input wire logic cmp,
  output logic busy,
  output logic sample,
  output logic [DATA_W-1:0] dac_code,
  output logic [DATA_W-1:0] result,
  output logic done
);

  conv_st_t st_reg;
  logic [7:0] cnt_reg;
  logic [3:0] bit_reg;
  logic [7:0] samp_eff;

  // Short sample settings are raised so a conversion never beats its minimum
  assign samp_eff = (samp < 8'(SAMPLE_MIN)) ? 8'(SAMPLE_MIN) : samp;
  assign busy = (st_reg != CV_IDLE);

  // Conversion sequence; start taken at once, later steps on conversion clock ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= CV_IDLE;
      cnt_reg <= 8'h00;
      bit_reg <= 4'h0;
      sample <= 1'b0;
      dac_code <= '0;
      result <= '0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        st_reg <= CV_IDLE;
        sample <= 1'b0;
      end
      else
      begin
        case (st_reg)
          CV_IDLE:
            if (start)
            begin
              st_reg <= CV_SAMP;
              cnt_reg <= samp_eff;
              sample <= 1'b1;
              dac_code <= '0;
            end
          CV_SAMP:
            if (tick)
            begin
              if (cnt_reg == 8'h01)
              begin
                st_reg <= CV_BITS;
                sample <= 1'b0;
                bit_reg <= 4'(DATA_W - 1);
                dac_code <= DATA_W'(1) << (DATA_W - 1);
              end
              else
                cnt_reg <= cnt_reg - 8'h01;
            end
          CV_BITS:
            if (tick)
            begin
              // Comparator high means the input is at or above the trial level
              dac_code[bit_reg] <= cmp;
              if (bit_reg == 4'h0)
              begin
                st_reg <= CV_SETTLE;
                cnt_reg <= 8'(SETTLE_CLK);
              end
              else
              begin
                bit_reg <= bit_reg - 4'h1;
                dac_code[bit_reg - 4'h1] <= 1'b1;
              end
            end
          CV_SETTLE:
            if (tick)
            begin
              if (cnt_reg == 8'h01)
              begin
                st_reg <= CV_IDLE;
                result <= dac_code;
                done <= 1'b1;
              end
              else
                cnt_reg <= cnt_reg - 8'h01;
            end
          default:
            st_reg <= CV_IDLE;
        endcase
      end
    end
  end

  // Helper counters for the checks below
  logic [8:0] tick_seen; // Wide enough for the longest sample setting
  logic [7:0] samp_seen;
  logic [7:0] samp_lat;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_seen <= 9'h000;
      samp_seen <= 8'h00;
      samp_lat <= 8'h00;
    end
    else
    begin
      if (st_reg == CV_IDLE && start)
      begin
        tick_seen <= 9'h000;
        samp_seen <= 8'h00;
        samp_lat <= samp_eff;
      end
      else if (tick && busy)
      begin
        tick_seen <= tick_seen + 9'h001;
        if (sample)
          samp_seen <= samp_seen + 8'h01;
      end
    end
  end

  property p_min_clocks;
    @(posedge pclk) disable iff (!presetn)
    done |-> tick_seen >= 9'(CONV_MIN_CLK);
  endproperty
  a_min_clocks: assert property (p_min_clocks) else $error("conversion too short");

  property p_sample_len;
    @(posedge pclk) disable iff (!presetn)
    $fell(sample) && !$past(abort) |-> samp_seen == samp_lat;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample window wrong");

endmodule
`default_nettype wire

// ---- core/sar_seq_ctrl.sv ----
// Converter controller top: APB registers, clock divider, channel sequencer,
// result buffers, window compare and interrupt. Analog pins are outside.
// Assumes cmp_in and lp_mode arrive asynchronously from the analog side.
//
// How it works
// - Conversion clock divided to at most 18 MHz
// - Each conversion spans at least 18 conversion clocks
// - Reference select: supply, half, bandgap, external
// - Sample window length set by software
// - Eight channels multiplexed, mask picks scan members
// - Started scan steps channels without CPU help
// - No idle clocks between channel conversions
// - Advance by state machine or firmware writes
// - Latest result kept per channel
// - Each channel picks one of four shared sample times
// - Results outside low/high window raise interrupt
// - Window interrupt raised right after that conversion
// - Temperature sensor selectable as input source
// - Unavailable in deep sleep or hibernate
`timescale 1ns/1ps
`default_nettype none
module sar_seq_ctrl
  import sar_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic cmp_in,
  input wire logic lp_mode,
  output logic [CH_W-1:0] mux_sel,
  output logic [1:0] ref_sel,
  output logic temp_en,
  output logic sh_sample,
  output logic [DATA_W-1:0] dac_code
);

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  ctrl_t ctrl_reg;
  logic [NCH-1:0] mask_reg;
  logic [7:0] div_reg;
  logic [2*NCH-1:0] ssel_reg;
  logic [31:0] stime_reg;
  logic [DATA_W-1:0] lo_reg;
  logic [DATA_W-1:0] hi_reg;
  logic [INT_W-1:0] intr_reg;
  logic [INT_W-1:0] intr_next;
  logic [INT_W-1:0] ien_reg;
  logic [DATA_W:0] res_mem [NCH];
  seq_st_t st_reg;
  seq_st_t st_next;
  logic [CH_W-1:0] cur_reg;
  logic [CH_W-1:0] cur_next;
  logic [7:0] div_cnt;
  logic tick;
  logic cmp_s1, cmp_s2, lp_s1, lp_s2;

  // Lowest mask bit at or above from; top bit flags a hit
  function automatic logic [CH_W:0] find_ch(input logic [NCH-1:0] m,
                                            input logic [CH_W-1:0] from);
    logic [CH_W:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--)
      if (m[i] && CH_W'(i) >= from)
        r = {1'b1, CH_W'(i)};
    return r;
  endfunction

  // Sample time picked by a channel's two-bit selector
  function automatic logic [7:0] samp_for(input logic [2*NCH-1:0] ss,
                                          input logic [31:0] times,
                                          input logic [CH_W-1:0] ch);
    logic [1:0] sel;
    sel = ss[2*ch +: 2];
    return times[8*sel +: 8];
  endfunction

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic setup, wr, hit_res, mapped, start_cmd, stop_cmd, fw_wr;
  logic [7:0] off;
  logic [CH_W-1:0] res_idx;
  logic [31:0] rd_data;
  assign setup = psel & ~penable;
  // Refused accesses (pslverr) must not reach any register through an alias
  assign wr = psel & penable & pready & pwrite & ~pslverr;
  assign off = paddr[7:0];
  assign res_idx = paddr[5:2];
  assign hit_res = (off >= OFF_RES) && (off < OFF_RES + 8'(4 * NCH)) && (paddr[1:0] == 2'b00);
  assign mapped = (paddr[ADDR_W-1:8] == '0) && (hit_res || (off <= OFF_IEN && off[1:0] == 2'b00));
  assign start_cmd = wr && off == OFF_CMD && pwdata[CMD_START];
  assign stop_cmd = wr && off == OFF_CMD && pwdata[CMD_STOP];
  assign fw_wr = wr && off == OFF_FWCH;

  // Read mux; write-only and command words read as zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit_res)
      rd_data = {res_mem[res_idx][DATA_W], 19'h0, res_mem[res_idx][DATA_W-1:0]};
    else
      case (off)
        OFF_CTRL: rd_data = 32'(ctrl_reg);
        OFF_MASK: rd_data = 32'(mask_reg);
        OFF_DIV: rd_data = 32'(div_reg);
        OFF_SSEL: rd_data = 32'(ssel_reg);
        OFF_STIME: rd_data = stime_reg;
        OFF_LIMIT: rd_data = {4'h0, hi_reg, 4'h0, lo_reg};
        OFF_STAT: rd_data = {20'h0, lp_s2, st_reg, cur_reg, 1'b0, sh_sample,
                             dac_code[DATA_W-1], st_reg != ST_IDLE};
        OFF_INTR: rd_data = 32'(intr_reg);
        OFF_IEN: rd_data = 32'(ien_reg);
        default: rd_data = 32'h0000_0000;
      endcase
  end

  // One wait-free access phase; answer registered during setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      prdata <= (setup && !pwrite && mapped) ? rd_data : 32'h0000_0000;
      pslverr <= setup && !mapped;
    end
  end

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= '0;
      mask_reg <= '0;
      div_reg <= DIV_RST;
      ssel_reg <= '0;
      stime_reg <= STIME_RST;
      lo_reg <= LIM_LO_RST;
      hi_reg <= LIM_HI_RST;
      ien_reg <= '0;
    end
    else if (wr)
    begin
      case (off)
        OFF_CTRL: ctrl_reg <= pwdata[$bits(ctrl_t)-1:0];
        OFF_MASK: mask_reg <= pwdata[NCH-1:0];
        OFF_DIV: div_reg <= pwdata[7:0];
        OFF_SSEL: ssel_reg <= pwdata[2*NCH-1:0];
        OFF_STIME: stime_reg <= pwdata;
        OFF_LIMIT:
        begin
          lo_reg <= pwdata[DATA_W-1:0];
          hi_reg <= pwdata[LIM_HI_LSB +: DATA_W];
        end
        OFF_IEN: ien_reg <= pwdata[INT_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Pin synchronisers and conversion clock divider
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {cmp_s1, cmp_s2, lp_s1, lp_s2} <= 4'h0;
    else
      {cmp_s1, cmp_s2, lp_s1, lp_s2} <= {cmp_in, cmp_s1, lp_mode, lp_s1};
  end

  // Divide never drops below DIV_MIN, whatever software writes
  logic [7:0] div_eff;
  logic can_run;
  assign div_eff = (div_reg < 8'(DIV_MIN)) ? 8'(DIV_MIN) : div_reg;
  assign can_run = ctrl_reg.enable && !lp_s2;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= can_run && div_cnt == div_eff - 8'h01;
      div_cnt <= (!can_run || div_cnt == div_eff - 8'h01) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic eng_start, eng_abort, eng_busy, eng_done;
  logic [DATA_W-1:0] eng_res;
  logic [CH_W:0] first_w, adv_w;
  logic start_scan, fw_go, out_win, eos;
  assign first_w = find_ch(mask_reg, '0);
  assign adv_w = find_ch(mask_reg, CH_W'(cur_reg + 4'h1));
  assign start_scan = start_cmd && can_run && st_reg == ST_IDLE && !ctrl_reg.fw_mode
                      && first_w[CH_W];
  assign fw_go = fw_wr && can_run && st_reg == ST_IDLE && ctrl_reg.fw_mode
                 && pwdata[CH_W-1:0] < CH_W'(NCH);
  assign eos = st_reg == ST_SCAN && eng_done && !adv_w[CH_W];
  assign eng_abort = !can_run || stop_cmd;
  assign out_win = (eng_res < lo_reg) || (eng_res > hi_reg);

  // Next channel and state; a new conversion starts in the done cycle
  always_comb
  begin
    st_next = st_reg;
    cur_next = cur_reg;
    eng_start = 1'b0;
    case (st_reg)
      ST_IDLE:
        if (start_scan)
        begin
          st_next = ST_SCAN;
          cur_next = first_w[CH_W-1:0];
          eng_start = 1'b1;
        end
        else if (fw_go)
        begin
          st_next = ST_FW;
          cur_next = pwdata[CH_W-1:0];
          eng_start = 1'b1;
        end
      ST_SCAN:
        if (eng_done && adv_w[CH_W])
        begin
          cur_next = adv_w[CH_W-1:0];
          eng_start = 1'b1;
        end
        else if (eos && ctrl_reg.cont && first_w[CH_W])
        begin
          cur_next = first_w[CH_W-1:0];
          eng_start = 1'b1;
        end
        else if (eos)
          st_next = ST_IDLE;
      ST_FW:
        if (eng_done)
          st_next = ST_IDLE;
      default:
        st_next = ST_IDLE;
    endcase
    if (eng_abort)
    begin
      st_next = ST_IDLE;
      eng_start = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= ST_IDLE;
      cur_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      cur_reg <= cur_next;
    end
  end

  // Result buffers, one per channel; never cleared by reads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NCH; i++)
        res_mem[i] <= '0;
    end
    else if (eng_done && st_reg != ST_IDLE)
      res_mem[cur_reg] <= {1'b1, eng_res};
  end

  // ****************************************************************
  // Interrupts: sticky status, set beats clear
  // ****************************************************************
  logic [INT_W-1:0] ev, clr;
  logic [INT_W-1:0] ien_next;
  // An enable write reaches irq at the same edge as the enable register
  assign ien_next = (wr && off == OFF_IEN) ? pwdata[INT_W-1:0] : ien_reg;
  assign ev = {eng_done && out_win, eos, eng_done} & {INT_W{st_reg != ST_IDLE}};
  assign clr = (wr && off == OFF_ICLR) ? pwdata[INT_W-1:0] : '0;
  assign intr_next = (intr_reg & ~clr) | ev;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      intr_reg <= '0;
      irq <= 1'b0;
    end
    else
    begin
      intr_reg <= intr_next;
      irq <= |(intr_next & ien_next);
    end
  end

  sar_conv u_conv (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .start(eng_start),
    .abort(eng_abort),
    .samp(samp_for(ssel_reg, stime_reg, cur_next)),
    .cmp(cmp_s2),
    .busy(eng_busy),
    .sample(sh_sample),
    .dac_code(dac_code),
    .result(eng_res),
    .done(eng_done)
  );

  assign mux_sel = cur_reg;
  assign ref_sel = ctrl_reg.ref_sel;
  assign temp_en = mask_reg[TEMP_CH];

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_tick_gap;
    @(posedge pclk) disable iff (!presetn)
    tick |=> !tick ##1 !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("conversion clock too fast");

  property p_autostep;
    @(posedge pclk) disable iff (!presetn)
    st_reg == ST_SCAN && eng_done && adv_w[CH_W] && !eng_abort
      |=> eng_busy && mux_sel == $past(adv_w[CH_W-1:0]);
  endproperty
  a_autostep: assert property (p_autostep) else $error("scan did not step");

  property p_no_gap;
    @(posedge pclk) disable iff (!presetn)
    st_reg == ST_SCAN && eng_done && !eng_abort
      && (adv_w[CH_W] || (ctrl_reg.cont && first_w[CH_W]))
      |=> sh_sample;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("idle gap between channels");

  property p_buffer;
    @(posedge pclk) disable iff (!presetn)
    eng_done && st_reg != ST_IDLE |=> res_mem[$past(cur_reg)] == {1'b1, $past(eng_res)};
  endproperty
  a_buffer: assert property (p_buffer) else $error("result not buffered");

  property p_range;
    @(posedge pclk) disable iff (!presetn)
    eng_done && st_reg != ST_IDLE && out_win |=> intr_reg[INT_RANGE];
  endproperty
  a_range: assert property (p_range) else $error("window flag missed");

  property p_scan_end;
    @(posedge pclk) disable iff (!presetn)
    eos && !ctrl_reg.cont |=> st_reg == ST_IDLE && intr_reg[INT_EOS];
  endproperty
  a_scan_end: assert property (p_scan_end) else $error("scan end wrong");

  property p_low_power;
    @(posedge pclk) disable iff (!presetn)
    lp_s2 |=> st_reg == ST_IDLE && !eng_busy && !tick;
  endproperty
  a_low_power: assert property (p_low_power) else $error("runs in low power");

  property p_fw_select;
    @(posedge pclk) disable iff (!presetn)
    fw_go && !eng_abort |=> st_reg == ST_FW && mux_sel == $past(pwdata[CH_W-1:0]);
  endproperty
  a_fw_select: assert property (p_fw_select) else $error("firmware select ignored");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    |(intr_reg & ien_reg) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt line low");

endmodule
`default_nettype wire

// ---- bench/analog_side.sv ----
// Analog far side of the converter: input levels and the comparator.
// Assumes mux_sel and dac_code come registered from the controller.
`timescale 1ns/1ps
`default_nettype none
module analog_side
  import sar_pkg::*;
(
  input wire logic [CH_W-1:0] mux_sel,
  input wire logic [DATA_W-1:0] dac_code,
  input wire logic temp_en,
  output logic cmp_in
);
  logic [DATA_W-1:0] level;
  // Pins carry fixed levels; the sensor reads zero while its bias is off
  always_comb
  begin
    if (mux_sel == TEMP_CH)
      level = temp_en ? 12'h7c3 : 12'h000;
    else
      level = {mux_sel[2:0], 9'h0a5};
    cmp_in = (level >= dac_code); // Answers within the same pclk
  end
endmodule
`default_nettype wire

// ---- bench/sar_seq_ctrl_bench.sv ----
// Self-checking bench for the converter controller over APB.
// Assumes the analog side model answers the comparator within one pclk.
`timescale 1ns/1ps
`default_nettype none
module sar_seq_ctrl_bench;
  import sar_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lp_mode = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, cmp_in, temp_en, sh_sample, er;
  logic [CH_W-1:0] mux_sel;
  logic [1:0] ref_sel;
  logic [DATA_W-1:0] dac_code;
  int num_errors = 0, n_tests = 0, scnt = 0;
  int slen [NCH];

  sar_seq_ctrl sar_seq_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .cmp_in(cmp_in), .lp_mode(lp_mode), .mux_sel(mux_sel),
    .ref_sel(ref_sel), .temp_en(temp_en), .sh_sample(sh_sample), .dac_code(dac_code));
  analog_side analog_side_i (.mux_sel(mux_sel), .dac_code(dac_code), .temp_en(temp_en),
    .cmp_in(cmp_in));

  initial forever #10 pclk = ~pclk;

  // Sample window length in pclk, kept per channel
  always @(posedge pclk)
  begin
    if (sh_sample === 1'b1) scnt <= scnt + 1;
    else if (scnt != 0)
    begin
      slen[mux_sel] <= scnt;
      scnt <= 0;
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; answer taken at the rising edge where pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) chk(32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Bounded wait for the interrupt line to reach a level
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 3000)
    begin
      @(negedge pclk);
      n++;
    end
    chk(32'(n < 3000), 32'h1);
  endtask

  function automatic logic [31:0] res(input int ch);
    return {1'b1, 19'h0, (ch == 8) ? 12'h7c3 : 12'(ch * 512 + 'ha5)};
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rdc(OFF_CTRL, 32'h0);
    rdc(OFF_DIV, 32'h3);
    rdc(OFF_STIME, STIME_RST);
    rdc(OFF_LIMIT, 32'h0fff0000);
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // High address bits set: refused, and the control word must not change
    apb(1'b1, 12'h100, 32'h1);
    chk({31'h0, er}, 32'h1);
    rdc(OFF_CTRL, 32'h0);
  endtask

  task automatic t_ref;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, OFF_CTRL, 32'(i << 3));
      @(negedge pclk);
      chk({30'h0, ref_sel}, 32'(i));
    end
  endtask

  // Divide forced up, per-channel sample time, window hit mid-scan
  task automatic t_scan;
    apb(1'b1, OFF_DIV, 32'h1);
    apb(1'b1, OFF_SSEL, 32'h80);
    apb(1'b1, OFF_LIMIT, 32'h06000200);
    apb(1'b1, OFF_MASK, 32'h109);
    apb(1'b1, OFF_IEN, 32'h4);
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b1, OFF_CMD, 32'h1);
    wait_irq(1'b1);
    apb(1'b0, OFF_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    apb(1'b1, OFF_IEN, 32'h2);
    wait_irq(1'b0);
    wait_irq(1'b1);
    rdc(OFF_INTR, 32'h7);
    rdc(OFF_RES, res(0));
    rdc(OFF_RES + 8'h0c, res(3));
    rdc(OFF_RES + 8'h20, res(8));
    rdc(OFF_RES + 8'h04, 32'h0);
    apb(1'b0, OFF_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
    chk(32'(slen[0] >= 9 && slen[0] <= 15), 32'h1);
    chk(32'(slen[3] >= 93 && slen[3] <= 99), 32'h1);
    apb(1'b1, OFF_ICLR, 32'h7);
    rdc(OFF_INTR, 32'h0);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_fw;
    apb(1'b1, OFF_CTRL, 32'h5);
    apb(1'b1, OFF_IEN, 32'h1);
    apb(1'b1, OFF_FWCH, 32'h5);
    wait_irq(1'b1);
    rdc(OFF_RES + 8'h14, res(5));
    apb(1'b1, OFF_ICLR, 32'h7);
  endtask

  // Continuous scan restarts after its end, then a stop halts it
  task automatic t_cont;
    apb(1'b1, OFF_CTRL, 32'h3);
    apb(1'b1, OFF_IEN, 32'h2);
    apb(1'b1, OFF_CMD, 32'h1);
    wait_irq(1'b1);
    apb(1'b1, OFF_ICLR, 32'h7);
    apb(1'b0, OFF_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    apb(1'b1, OFF_CMD, 32'h2);
    apb(1'b0, OFF_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
  endtask

  task automatic t_lp;
    lp_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b1, OFF_CMD, 32'h1);
    apb(1'b0, OFF_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
    chk({31'h0, rd[11]}, 32'h1);
    lp_mode <= 1'b0;
  endtask

  task automatic summarize;
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run is under a thousand cycles; cut a hang well beyond that
  initial
  begin
    #800000;
    num_errors++;
    summarize();
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ref();
    t_scan();
    t_fw();
    t_cont();
    t_lp();
    summarize();
  end
endmodule
`default_nettype wire
